// file: hdl/ddr3_init_ctrl.sv
// DDR3 reset scope, init sequencer, mode register values and burst turnaround
`timescale 1ns/1ns
`default_nettype none

// Contract
// R1: Hard reset clears state, queue, all registers
// R2: Soft reset clears state, queue; keeps configuration
// R3: No register access while either reset
// R4: Same-type same-chip bursts: zero idle cycles
// R5: Different chip select: turnaround plus one
// R6: Read after write: delay plus one plus CL
// R7: Write after read: delay plus one
// R8: Init after any reset and config write
// R9: Init ends with refresh, banks precharged
// R10: Reset init starts at once, queue dropped
// R11: Config-write init drains queue first
// R12: BA low bits select; BA2, A15-13 zero
// R13: MR2 uses BA 2, MR1 uses BA 1
// R14: MR3 written all zero
// R15: MR2 reserved zero, termination in 10-9
// R16: MR2 SELF_REFRESH_TEMP_RANGE, AUTO_SELF_REFRESH_ENABLE, CAS_WRITE_LATENCY, PARTIAL_ARRAY_REFRESH from configuration
// R17: MR1 fixed fields: outputs on, DLL on
// R18: MR1 bits 9,6,2 carry termination select
// R19: MR1 bits 5,1 carry drive strength
// R20: MR0 write recovery 11-9, DLL reset set
// R21: MR0 bits 6-4 carry CL bits 3-1
// R22: MR0 bits 12, 7, 3 zero
// R23: MR0 via BA 0, CL0 bit 2, BL8
// R24: Reset init needs DDR3 type, not disabled
// R25: No transactions before init completes
// R26: Order MR2, MR3, MR1, MR0 with spacing
module ddr3_init_ctrl #(
  parameter int INIT_WAIT_CYCLES = ddr3_init_pkg::INIT_WAIT_CK
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic soft_rstn,
  input wire logic cfg_write,
  input wire logic [2:0] memory_type,
  input wire logic [1:0] dynamic_termination_field,
  input wire logic [1:0] write_termination_copy,
  input wire logic self_refresh_temp_range,
  input wire logic auto_self_refresh_enable,
  input wire logic [2:0] cas_write_latency,
  input wire logic [2:0] termination_select,
  input wire logic [1:0] drive_strength,
  input wire logic [3:0] cas_latency,
  input wire logic aux_write,
  input wire logic [2:0] partial_array_refresh,
  input wire logic init_disable_bit,
  input wire logic [2:0] write_recovery,
  input wire logic [1:0] chip_select_turnaround,
  input wire logic [2:0] write_to_read_delay,
  input wire logic [2:0] read_to_write_delay,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_cs,
  output logic req_ready,
  output logic init_done,
  output logic termination_mismatch,
  output logic mem_cke,
  output logic [2:0] mem_cmd,
  output logic [2:0] mem_ba,
  output logic [15:0] mem_addr,
  output logic mem_cs,
  output logic burst_start,
  output logic burst_write
);

  // ------
  // Soft reset synchroniser
  // ------
  logic soft_meta_q;
  logic soft_sync_q;
  logic soft_act;
  logic reg_access_ok;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      soft_meta_q <= 1'h1;
      soft_sync_q <= 1'h1;
    end else begin
      soft_meta_q <= soft_rstn;
      soft_sync_q <= soft_meta_q;
    end
  end

  assign soft_act = !soft_sync_q;
  // Access strobes dropped while either reset is active
  assign reg_access_ok = rstn && !soft_act; // [R3]

  // ------
  // Configuration registers
  // ------
  // Soft reset leaves these alone; only hard reset clears them
  logic [2:0] mem_type_q, mem_type_d;
  logic [1:0] dyn_term_q, dyn_term_d;
  logic [1:0] wr_term_copy_q, wr_term_copy_d;
  logic srt_q, srt_d;
  logic asr_q, asr_d;
  logic [2:0] cwl_q, cwl_d;
  logic [2:0] term_sel_q, term_sel_d;
  logic [1:0] drive_q, drive_d;
  logic [3:0] cas_lat_q, cas_lat_d;
  logic [2:0] partial_array_refresh_q, partial_array_refresh_d;
  logic init_dis_q, init_dis_d;
  logic [2:0] wr_recov_q, wr_recov_d;
  logic [1:0] cs_ta_q, cs_ta_d;
  logic [2:0] wtr_q, wtr_d;
  logic [2:0] rtw_q, rtw_d;

  always_comb begin
    mem_type_d = mem_type_q;
    dyn_term_d = dyn_term_q;
    wr_term_copy_d = wr_term_copy_q;
    srt_d = srt_q;
    asr_d = asr_q;
    cwl_d = cwl_q;
    term_sel_d = term_sel_q;
    drive_d = drive_q;
    cas_lat_d = cas_lat_q;
    partial_array_refresh_d = partial_array_refresh_q;
    init_dis_d = init_dis_q;
    wr_recov_d = wr_recov_q;
    cs_ta_d = cs_ta_q;
    wtr_d = wtr_q;
    rtw_d = rtw_q;
    if (cfg_write && reg_access_ok) begin // [R3]
      mem_type_d = memory_type;
      dyn_term_d = dynamic_termination_field;
      wr_term_copy_d = write_termination_copy;
      srt_d = self_refresh_temp_range;
      asr_d = auto_self_refresh_enable;
      cwl_d = cas_write_latency;
      term_sel_d = termination_select;
      drive_d = drive_strength;
      cas_lat_d = cas_latency;
    end
    if (aux_write && reg_access_ok) begin // [R3]
      partial_array_refresh_d = partial_array_refresh;
      init_dis_d = init_disable_bit;
      wr_recov_d = write_recovery;
      cs_ta_d = chip_select_turnaround;
      wtr_d = write_to_read_delay;
      rtw_d = read_to_write_delay;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin // [R1]
      mem_type_q <= ddr3_init_pkg::RST_MEM_TYPE;
      dyn_term_q <= ddr3_init_pkg::RST_DYN_TERM;
      wr_term_copy_q <= ddr3_init_pkg::RST_WR_TERM_COPY;
      srt_q <= ddr3_init_pkg::RST_SRT;
      asr_q <= ddr3_init_pkg::RST_ASR;
      cwl_q <= ddr3_init_pkg::RST_CWL;
      term_sel_q <= ddr3_init_pkg::RST_TERM_SEL;
      drive_q <= ddr3_init_pkg::RST_DRIVE;
      cas_lat_q <= ddr3_init_pkg::RST_CAS_LAT;
      partial_array_refresh_q <= ddr3_init_pkg::RST_PARTIAL_ARRAY_REFRESH;
      init_dis_q <= ddr3_init_pkg::RST_INIT_DIS;
      wr_recov_q <= ddr3_init_pkg::RST_WR_RECOV;
      cs_ta_q <= ddr3_init_pkg::RST_CS_TA;
      wtr_q <= ddr3_init_pkg::RST_WTR;
      rtw_q <= ddr3_init_pkg::RST_RTW;
    end else begin // [R2]
      mem_type_q <= mem_type_d;
      dyn_term_q <= dyn_term_d;
      wr_term_copy_q <= wr_term_copy_d;
      srt_q <= srt_d;
      asr_q <= asr_d;
      cwl_q <= cwl_d;
      term_sel_q <= term_sel_d;
      drive_q <= drive_d;
      cas_lat_q <= cas_lat_d;
      partial_array_refresh_q <= partial_array_refresh_d;
      init_dis_q <= init_dis_d;
      wr_recov_q <= wr_recov_d;
      cs_ta_q <= cs_ta_d;
      wtr_q <= wtr_d;
      rtw_q <= rtw_d;
    end
  end

  // ------
  // Mode register words
  // ------
  // A15-13 always zero in every word
  function automatic logic [15:0] mode_word(input logic [2:0] sel);
    logic [15:0] w;
    w = 16'h0000; // [R12]
    case (sel)
      ddr3_init_pkg::BA_MR2: begin
        w = {5'h00, dyn_term_q, 1'h0, srt_q, asr_q, cwl_q, partial_array_refresh_q}; // [R15] [R16]
      end
      ddr3_init_pkg::BA_MR3: begin
        w = ddr3_init_pkg::MR3_VALUE; // [R14]
      end
      ddr3_init_pkg::BA_MR1: begin
        // Qoff, TDQS, leveling, AL, DLL disable all held at zero
        w = {6'h00, term_sel_q[2], 2'h0, term_sel_q[1], drive_q[1], 2'h0, // [R17] [R18]
             term_sel_q[0], drive_q[0], 1'h0}; // [R19]
      end
      ddr3_init_pkg::BA_MR0: begin
        w = {4'h0, wr_recov_q, ddr3_init_pkg::MR0_DLL_RESET, 1'h0, // [R20] [R22]
             cas_lat_q[3:1], 1'h0, cas_lat_q[0], 2'h0}; // [R21] [R23]
      end
      default: begin
        w = 16'h0000;
      end
    endcase
    return w;
  endfunction

  // ------
  // Command queue
  // ------
  logic [3:0] q_write_q, q_write_d;
  logic [3:0] q_cs_q, q_cs_d;
  logic [1:0] wr_ptr_q, wr_ptr_d;
  logic [1:0] rd_ptr_q, rd_ptr_d;
  logic [2:0] count_q, count_d;
  logic req_ready_q, req_ready_d;
  logic cfg_pend_q, cfg_pend_d;
  logic issue;
  logic cfg_start;

  always_comb begin
    q_write_d = q_write_q;
    q_cs_d = q_cs_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    cfg_pend_d = cfg_pend_q;
    if (req_valid && req_ready_q) begin
      q_write_d[wr_ptr_q] = req_write;
      q_cs_d[wr_ptr_q] = req_cs;
      wr_ptr_d = wr_ptr_q + 2'h1;
      count_d = count_d + 3'h1;
    end
    if (issue) begin
      rd_ptr_d = rd_ptr_q + 2'h1;
      count_d = count_d - 3'h1;
    end
    // A pending re-init that starts clears the flag; a fresh write wins
    if (cfg_start) begin
      cfg_pend_d = 1'h0;
    end
    if (cfg_write && reg_access_ok) begin
      cfg_pend_d = 1'h1; // [R8]
    end
    // Intake stops while a re-init waits, so the queue really drains
    req_ready_d = (count_d != ddr3_init_pkg::QUEUE_FULL) && !cfg_pend_d; // [R11]
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || soft_act) begin // [R1] [R2] [R10]
      q_write_q <= 4'h0;
      q_cs_q <= 4'h0;
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q <= 3'h0;
      req_ready_q <= 1'h0;
      cfg_pend_q <= 1'h0;
    end else begin
      q_write_q <= q_write_d;
      q_cs_q <= q_cs_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      req_ready_q <= req_ready_d;
      cfg_pend_q <= cfg_pend_d;
    end
  end

  // ------
  // Turnaround tracking
  // ------
  logic last_valid_q;
  logic last_write_q;
  logic last_cs_q;
  logic [1:0] burst_cnt_q;
  logic [4:0] idle_cnt_q;
  logic [4:0] gap;
  logic head_write;
  logic head_cs;

  assign head_write = q_write_q[rd_ptr_q];
  assign head_cs = q_cs_q[rd_ptr_q];

  turnaround_gap u_gap (
    .prev_valid(last_valid_q),
    .prev_write(last_write_q),
    .prev_cs(last_cs_q),
    .next_write(head_write),
    .next_cs(head_cs),
    .chip_select_turnaround(cs_ta_q),
    .write_to_read_delay(wtr_q),
    .read_to_write_delay(rtw_q),
    .cas_latency(cas_lat_q),
    .gap(gap)
  );

  // ------
  // Init sequencer and scheduler
  // ------
  ddr3_init_pkg::init_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic cke_q, cke_d;
  logic [2:0] cmd_q, cmd_d;
  logic [2:0] ba_q, ba_d;
  logic [15:0] addr_q, addr_d;
  logic cs_q, cs_d;
  logic bstart_q, bstart_d;
  logic bwrite_q, bwrite_d;
  logic last_valid_d, last_write_d, last_cs_d;
  logic [1:0] burst_cnt_d;
  logic [4:0] idle_cnt_d;

  // Loads the counter for a wait of n cycles, n at least one
  function automatic logic [15:0] wait_of(input int n);
    return 16'(n - 1);
  endfunction

  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
    done_d = done_q;
    cke_d = cke_q;
    cmd_d = ddr3_init_pkg::CMD_NOP;
    ba_d = 3'h0;
    addr_d = 16'h0000;
    cs_d = cs_q;
    bstart_d = 1'h0;
    bwrite_d = bwrite_q;
    last_valid_d = last_valid_q;
    last_write_d = last_write_q;
    last_cs_d = last_cs_q;
    burst_cnt_d = (burst_cnt_q != 2'h0) ? burst_cnt_q - 2'h1 : burst_cnt_q;
    idle_cnt_d = idle_cnt_q;
    issue = 1'h0;
    cfg_start = 1'h0;
    case (state_q)
      ddr3_init_pkg::ST_RESET: begin
        cke_d = 1'h0;
        if ((mem_type_q == ddr3_init_pkg::DDR3_TYPE) && !init_dis_q) begin // [R24]
          state_d = ddr3_init_pkg::ST_PWR_WAIT; // [R8] [R10]
          cnt_d = wait_of(INIT_WAIT_CYCLES);
        end else begin
          state_d = ddr3_init_pkg::ST_IDLE;
          cke_d = 1'h1;
          done_d = 1'h1;
        end
      end
      ddr3_init_pkg::ST_PWR_WAIT: begin
        if (cnt_q == 16'h0000) begin
          cke_d = 1'h1;
          state_d = ddr3_init_pkg::ST_CKE_WAIT;
          cnt_d = wait_of(ddr3_init_pkg::T_XPR_CK);
        end
      end
      ddr3_init_pkg::ST_CKE_WAIT: begin
        if (cnt_q == 16'h0000) begin
          cmd_d = ddr3_init_pkg::CMD_MRS; // [R26]
          ba_d = ddr3_init_pkg::BA_MR2; // [R13]
          addr_d = mode_word(ddr3_init_pkg::BA_MR2);
          state_d = ddr3_init_pkg::ST_MR3;
          cnt_d = wait_of(ddr3_init_pkg::T_MRD_CK);
        end
      end
      ddr3_init_pkg::ST_MR3: begin
        if (cnt_q == 16'h0000) begin
          cmd_d = ddr3_init_pkg::CMD_MRS; // [R26]
          ba_d = ddr3_init_pkg::BA_MR3; // [R12]
          addr_d = mode_word(ddr3_init_pkg::BA_MR3);
          state_d = ddr3_init_pkg::ST_MR1;
          cnt_d = wait_of(ddr3_init_pkg::T_MRD_CK);
        end
      end
      ddr3_init_pkg::ST_MR1: begin
        if (cnt_q == 16'h0000) begin
          cmd_d = ddr3_init_pkg::CMD_MRS; // [R26]
          ba_d = ddr3_init_pkg::BA_MR1; // [R13]
          addr_d = mode_word(ddr3_init_pkg::BA_MR1);
          state_d = ddr3_init_pkg::ST_MR0;
          cnt_d = wait_of(ddr3_init_pkg::T_MRD_CK);
        end
      end
      ddr3_init_pkg::ST_MR0: begin
        if (cnt_q == 16'h0000) begin
          cmd_d = ddr3_init_pkg::CMD_MRS; // [R26]
          ba_d = ddr3_init_pkg::BA_MR0; // [R23]
          addr_d = mode_word(ddr3_init_pkg::BA_MR0);
          state_d = ddr3_init_pkg::ST_PREA;
          cnt_d = wait_of(ddr3_init_pkg::T_MOD_CK);
        end
      end
      ddr3_init_pkg::ST_PREA: begin
        if (cnt_q == 16'h0000) begin
          cmd_d = ddr3_init_pkg::CMD_PREA; // [R9]
          addr_d = 16'h0400;
          state_d = ddr3_init_pkg::ST_REF;
          cnt_d = wait_of(ddr3_init_pkg::T_RP_CK);
        end
      end
      ddr3_init_pkg::ST_REF: begin
        if (cnt_q == 16'h0000) begin
          cmd_d = ddr3_init_pkg::CMD_REF; // [R9]
          state_d = ddr3_init_pkg::ST_IDLE;
          cnt_d = wait_of(ddr3_init_pkg::T_RFC_CK);
        end
      end
      ddr3_init_pkg::ST_IDLE: begin
        // Done only once the closing refresh has had its full recovery
        if (!done_q && (cnt_q == 16'h0000)) begin
          done_d = 1'h1;
        end
        if (burst_cnt_q == 2'h0) begin
          idle_cnt_d = (idle_cnt_q != ddr3_init_pkg::IDLE_MAX) ? idle_cnt_q + 5'h01
                                                               : idle_cnt_q;
        end
        if (cfg_pend_q && (count_q == 3'h0) && (burst_cnt_q == 2'h0) && done_q) begin
          cfg_start = 1'h1; // [R11]
          done_d = 1'h0;
          cmd_d = ddr3_init_pkg::CMD_MRS; // [R8]
          ba_d = ddr3_init_pkg::BA_MR2;
          addr_d = mode_word(ddr3_init_pkg::BA_MR2);
          state_d = ddr3_init_pkg::ST_MR3;
          cnt_d = wait_of(ddr3_init_pkg::T_MRD_CK);
        end else if (done_q && (count_q != 3'h0) && (burst_cnt_q == 2'h0)
                     && (idle_cnt_q >= gap)) begin // [R25] [R4] [R5] [R6] [R7]
          issue = 1'h1;
          cmd_d = head_write ? ddr3_init_pkg::CMD_WR : ddr3_init_pkg::CMD_RD;
          cs_d = head_cs;
          bstart_d = 1'h1;
          bwrite_d = head_write;
          last_valid_d = 1'h1;
          last_write_d = head_write;
          last_cs_d = head_cs;
          burst_cnt_d = 2'(ddr3_init_pkg::BURST_CK - 1);
          idle_cnt_d = 5'h00;
        end
      end
      default: begin
        state_d = ddr3_init_pkg::ST_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || soft_act) begin // [R1] [R2]
      state_q <= ddr3_init_pkg::ST_RESET;
      cnt_q <= 16'h0000;
      done_q <= 1'h0;
      cke_q <= 1'h0;
      cmd_q <= ddr3_init_pkg::CMD_NOP;
      ba_q <= 3'h0;
      addr_q <= 16'h0000;
      cs_q <= 1'h0;
      bstart_q <= 1'h0;
      bwrite_q <= 1'h0;
      last_valid_q <= 1'h0;
      last_write_q <= 1'h0;
      last_cs_q <= 1'h0;
      burst_cnt_q <= 2'h0;
      idle_cnt_q <= 5'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      cke_q <= cke_d;
      cmd_q <= cmd_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
      cs_q <= cs_d;
      bstart_q <= bstart_d;
      bwrite_q <= bwrite_d;
      last_valid_q <= last_valid_d;
      last_write_q <= last_write_d;
      last_cs_q <= last_cs_d;
      burst_cnt_q <= burst_cnt_d;
      idle_cnt_q <= idle_cnt_d;
    end
  end

  // ------
  // Status
  // ------
  logic mismatch_q;

  // Software keeps the duplicate termination copy equal; flag when not
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mismatch_q <= 1'h0;
    end else begin
      mismatch_q <= (dyn_term_q != wr_term_copy_q); // [R15]
    end
  end

  assign req_ready = req_ready_q;
  assign init_done = done_q;
  assign termination_mismatch = mismatch_q;
  assign mem_cke = cke_q;
  assign mem_cmd = cmd_q;
  assign mem_ba = ba_q;
  assign mem_addr = addr_q;
  assign mem_cs = cs_q;
  assign burst_start = bstart_q;
  assign burst_write = bwrite_q;

endmodule

`default_nettype wire

// file: hdl/ddr3_init_pkg.sv
// Constants, encodings and field layouts for the DDR3 init and turnaround block
package ddr3_init_pkg;

  // ------
  // Clock and timing
  // ------
  localparam int CLK_PERIOD_NS = 40;
  localparam int INIT_WAIT_US = 500;
  localparam int INIT_WAIT_CK = (INIT_WAIT_US * 1000) / CLK_PERIOD_NS;
  localparam int T_XPR_NS = 120;
  localparam int T_XPR_CK = (T_XPR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RP_NS = 15;
  localparam int T_RP_CK = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RFC_NS = 110;
  localparam int T_RFC_CK = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_MRD_CK = 4;
  localparam int T_MOD_CK = 12;
  localparam int BURST_CK = 4;

  // ------
  // Queue and counters
  // ------
  localparam int QUEUE_DEPTH = 4;
  localparam logic [2:0] QUEUE_FULL = 3'h4;
  localparam logic [4:0] IDLE_MAX = 5'h1F;

  // ------
  // Memory command encoding
  // ------
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_MRS = 3'h1;
  localparam logic [2:0] CMD_REF = 3'h2;
  localparam logic [2:0] CMD_PREA = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h4;
  localparam logic [2:0] CMD_WR = 3'h5;

  // ------
  // Mode register selects and fixed values
  // ------
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam logic [15:0] MR3_VALUE = 16'h0000;
  localparam logic MR0_DLL_RESET = 1'h1;
  localparam logic [2:0] DDR3_TYPE = 3'h3;

  // ------
  // Configuration reset values
  // ------
  localparam logic [2:0] RST_MEM_TYPE = 3'h3;
  localparam logic [1:0] RST_DYN_TERM = 2'h0;
  localparam logic [1:0] RST_WR_TERM_COPY = 2'h0;
  localparam logic RST_SRT = 1'h0;
  localparam logic RST_ASR = 1'h0;
  localparam logic [2:0] RST_CWL = 3'h0;
  localparam logic [2:0] RST_TERM_SEL = 3'h0;
  localparam logic [1:0] RST_DRIVE = 2'h0;
  localparam logic [3:0] RST_CAS_LAT = 4'h2;
  localparam logic [2:0] RST_PARTIAL_ARRAY_REFRESH = 3'h0;
  localparam logic RST_INIT_DIS = 1'h0;
  localparam logic [2:0] RST_WR_RECOV = 3'h0;
  localparam logic [1:0] RST_CS_TA = 2'h0;
  localparam logic [2:0] RST_WTR = 3'h0;
  localparam logic [2:0] RST_RTW = 3'h0;

  // ------
  // Controller states, Gray along the init path
  // ------
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_PWR_WAIT = 4'h1,
    ST_CKE_WAIT = 4'h3,
    ST_MR3 = 4'h2,
    ST_MR1 = 4'h6,
    ST_MR0 = 4'h7,
    ST_PREA = 4'h5,
    ST_REF = 4'h4,
    ST_IDLE = 4'hC
  } init_state_t;

endpackage

// file: hdl/turnaround_gap.sv
// Idle data-bus cycles needed between two back-to-back bursts
`timescale 1ns/1ns
`default_nettype none

module turnaround_gap (
  input wire logic prev_valid,
  input wire logic prev_write,
  input wire logic prev_cs,
  input wire logic next_write,
  input wire logic next_cs,
  input wire logic [1:0] chip_select_turnaround,
  input wire logic [2:0] write_to_read_delay,
  input wire logic [2:0] read_to_write_delay,
  input wire logic [3:0] cas_latency,
  output logic [4:0] gap
);

  always_comb begin
    gap = 5'h00;
    if (prev_valid) begin
      if (prev_write && !next_write) begin
        gap = 5'({2'h0, write_to_read_delay} + 5'h01 + {1'h0, cas_latency}); // [R6]
      end else if (!prev_write && next_write) begin
        gap = 5'({2'h0, read_to_write_delay} + 5'h01); // [R7]
      end else if (prev_cs != next_cs) begin
        gap = 5'({3'h0, chip_select_turnaround} + 5'h01); // [R5]
      end else begin
        gap = 5'h00; // [R4]
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/ddr3_init_properties.sv
// Concurrent checks on the DDR3 init block ports
`timescale 1ns/1ns
`default_nettype none
module ddr3_init_properties (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic mem_cke,
  input wire logic [2:0] mem_cmd,
  input wire logic [2:0] mem_ba,
  input wire logic [15:0] mem_addr,
  input wire logic init_done,
  input wire logic req_ready,
  input wire logic burst_start
);
  localparam logic [2:0] MRS = ddr3_init_pkg::CMD_MRS;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_mr(logic [2:0] b);
    mem_cmd == MRS && mem_ba == b;
  endsequence
  // Fixed spacing keeps the tail of the chain predictable
  sequence s_chain;
    ##4 s_mr(3'h3) ##4 s_mr(3'h1) ##4 s_mr(3'h0);
  endsequence
  a_mrs_upper_zero: assert property (mem_cmd == MRS |-> !mem_ba[2] && !(|mem_addr[15:13]))
    else $error("mode write with upper bits set");
  a_mr3_all_zero: assert property (s_mr(3'h3) |-> mem_addr == 16'h0000)
    else $error("third extended register not zero");
  a_mr2_reserved: assert property (s_mr(3'h2) |-> mem_addr[15:11] == 5'h00 && !mem_addr[8])
    else $error("second extended register reserved bits set");
  a_mr1_fixed_bits: assert property (s_mr(3'h1) |-> mem_addr[12:10] == 3'h0
    && mem_addr[8:7] == 2'h0 && mem_addr[4:3] == 2'h0 && !mem_addr[0])
    else $error("first extended register fixed bits wrong");
  a_mr0_fixed_bits: assert property (s_mr(3'h0) |-> mem_addr[8] && !mem_addr[7]
    && mem_addr[15:12] == 4'h0 && !mem_addr[3] && mem_addr[1:0] == 2'h0)
    else $error("mode register fixed bits wrong");
  a_mode_order: assert property (s_mr(3'h2) |-> s_chain)
    else $error("mode register order or spacing wrong");
  a_init_tail: assert property (s_mr(3'h0) |-> ##12 mem_cmd == 3'h3 ##1 mem_cmd == 3'h2)
    else $error("precharge and refresh missing after mode writes");
  a_burst_length: assert property (burst_start |=> !burst_start [*3])
    else $error("burst shorter than four cycles");
  a_burst_after_init: assert property (burst_start |-> init_done)
    else $error("burst before init finished");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> mem_cmd == 3'h0
    && !mem_cke && !req_ready && !init_done)
    else $error("outputs active during reset");
endmodule
bind ddr3_init_ctrl ddr3_init_properties u_props (
  .ref_clk(ref_clk), .rstn(rstn), .mem_cke(mem_cke), .mem_cmd(mem_cmd), .mem_ba(mem_ba),
  .mem_addr(mem_addr), .init_done(init_done), .req_ready(req_ready), .burst_start(burst_start)
);
`default_nettype wire

// file: tb/ddr3_mem_model.sv
// Memory side model: takes mode register writes off the command bus
`timescale 1ns/1ns
`default_nettype none
module ddr3_mem_model (
  input wire logic ref_clk,
  input wire logic mem_cke,
  input wire logic [2:0] mem_cmd,
  input wire logic [2:0] mem_ba,
  input wire logic [15:0] mem_addr,
  output logic mrs_seen,
  output logic [1:0] mr_sel,
  output logic [15:0] mr_value
);
  initial mrs_seen = 1'b0;
  // Ignored while clock enable is low, as a real part would
  always @(posedge ref_clk) begin
    mrs_seen <= mem_cke && mem_cmd == ddr3_init_pkg::CMD_MRS;
    if (mem_cke && mem_cmd == ddr3_init_pkg::CMD_MRS) begin
      mr_sel <= mem_ba[1:0];
      mr_value <= mem_addr;
    end
  end
endmodule
`default_nettype wire

// file: tb/test_ddr3_init_ctrl.sv
// Self-checking bench: reset and config init, mode values, turnaround gaps
`timescale 1ns/1ns
`default_nettype none
module test_ddr3_init_ctrl;
  logic ref_clk = 1'b0, rstn = 1'b0, soft_rstn = 1'b1, cfg_write = 1'b0, aux_write = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_cs = 1'b0, init_disable_bit = 1'b0;
  logic self_refresh_temp_range = 1'b0, auto_self_refresh_enable = 1'b0;
  logic [1:0] dynamic_termination_field = 2'h0, write_termination_copy = 2'h0;
  logic [1:0] drive_strength = 2'h0, chip_select_turnaround = 2'h0;
  logic [2:0] memory_type = 3'h3, cas_write_latency = 3'h0, termination_select = 3'h0;
  logic [2:0] partial_array_refresh = 3'h0, write_recovery = 3'h0, write_to_read_delay = 3'h0;
  logic [2:0] read_to_write_delay = 3'h0, mem_cmd, mem_ba;
  logic [3:0] cas_latency = 4'h2;
  logic req_ready, init_done, termination_mismatch, mem_cke, mem_cs, burst_start, burst_write;
  logic mrs_seen;
  logic [1:0] mr_sel;
  logic [15:0] mem_addr, mr_value;
  logic [20:0] notes [$];
  logic [20:0] exp;
  logic [4:0] gap;
  int cyc = 0, last = 0, errors = 0, comparisons = 0;

  ddr3_init_ctrl #(.INIT_WAIT_CYCLES(20)) dut (.*);
  ddr3_mem_model mem (.*);
  always #20 ref_clk = ~ref_clk;

  // ------
  // Shared tasks
  // ------
  task automatic check(input logic [20:0] seen, input logic [20:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic expect_init(input logic [1:0] dy, input logic sr, input logic as,
      input logic [2:0] cw, input logic [2:0] pa, input logic [2:0] ts, input logic [1:0] dr,
      input logic [2:0] wr, input logic [3:0] cl);
    notes.push_back({5'h12, 5'h00, dy, 1'b0, sr, as, cw, pa});
    notes.push_back({5'h13, 16'h0000});
    notes.push_back({5'h11, 6'h00, ts[2], 2'h0, ts[1], dr[1], 2'h0, ts[0], dr[0], 1'b0});
    notes.push_back({5'h10, 4'h0, wr, 2'h2, cl[3:1], 1'b0, cl[0], 2'h0});
  endtask
  task automatic expect_cur();
    expect_init(dynamic_termination_field, self_refresh_temp_range, auto_self_refresh_enable,
      cas_write_latency, partial_array_refresh, termination_select, drive_strength,
      write_recovery, cas_latency);
  endtask
  task automatic strobe(input logic cfg);
    if (cfg) cfg_write = 1'b1;
    else aux_write = 1'b1;
    step(1);
    cfg_write = 1'b0;
    aux_write = 1'b0;
  endtask
  // Held until taken
  task automatic send(input logic w, input logic c, input logic chk, input logic [4:0] g);
    notes.push_back({1'b0, chk, 1'b0, c, w, 11'h000, g});
    req_valid = 1'b1;
    req_write = w;
    req_cs = c;
    while (req_ready !== 1'b1) step(1);
    step(1);
  endtask
  task automatic wait_idle(input string name);
    repeat (2000) begin
      if (notes.size() == 0 && init_done === 1'b1) break;
      step(1);
    end
    check({19'(notes.size()), termination_mismatch, init_done}, 21'h000001);
    $display("test %s done", name);
  endtask

  // ------
  // Output watcher, sampled mid-cycle
  // ------
  always @(negedge ref_clk) begin
    cyc++;
    if (mrs_seen === 1'b1) begin
      exp = (notes.size() > 0) ? notes.pop_front() : 'x;
      check({3'h4, mr_sel, mr_value}, exp);
    end
    if (burst_start === 1'b1) begin
      exp = (notes.size() > 0) ? notes.pop_front() : 'x;
      gap = exp[19] ? 5'(cyc - last - 4) : exp[4:0];
      last = cyc;
      check({1'b0, exp[19], 1'b0, mem_cs, burst_write, 11'h000, gap}, exp);
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    wrap_up();
  end

  // ------
  // Main sequence
  // ------
  initial begin
    logic [4:0] cs_gap, wr_gap, rw_gap;
    void'($urandom(40575));
    step(8);
    expect_init(2'h0, 1'h0, 1'h0, 3'h0, 3'h0, 3'h0, 2'h0, 3'h0, 4'h2);
    rstn = 1'b1;
    wait_idle("reset init");
    {dynamic_termination_field, self_refresh_temp_range, auto_self_refresh_enable,
      cas_write_latency, termination_select, drive_strength, cas_latency} = 16'($urandom);
    {partial_array_refresh, write_recovery, chip_select_turnaround, write_to_read_delay,
      read_to_write_delay} = 14'($urandom);
    auto_self_refresh_enable = auto_self_refresh_enable & !self_refresh_temp_range;
    write_termination_copy = dynamic_termination_field;
    strobe(1'b0);
    expect_cur();
    strobe(1'b1);
    wait_idle("config init");
    cs_gap = 5'(chip_select_turnaround) + 5'h01;
    wr_gap = 5'(write_to_read_delay) + 5'h01 + 5'(cas_latency);
    rw_gap = 5'(read_to_write_delay) + 5'h01;
    send(1'b1, 1'b0, 1'b0, 5'h00);
    send(1'b1, 1'b0, 1'b1, 5'h00);
    send(1'b1, 1'b1, 1'b1, cs_gap);
    send(1'b0, 1'b1, 1'b1, wr_gap);
    send(1'b0, 1'b1, 1'b1, 5'h00);
    send(1'b0, 1'b0, 1'b1, cs_gap);
    send(1'b1, 1'b0, 1'b1, rw_gap);
    req_valid = 1'b0;
    wait_idle("turnaround");
    send(1'b1, 1'b1, 1'b0, 5'h00);
    send(1'b0, 1'b1, 1'b1, wr_gap);
    req_valid = 1'b0;
    expect_cur();
    strobe(1'b1);
    wait_idle("config write with queued bursts");
    expect_cur();
    soft_rstn = 1'b0;
    step(3);
    soft_rstn = 1'b1;
    wait_idle("soft reset");
    cas_latency = 4'hF;
    expect_init(2'h0, 1'h0, 1'h0, 3'h0, 3'h0, 3'h0, 2'h0, 3'h0, 4'h2);
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    wait_idle("hard reset");
    wrap_up();
  end
endmodule
`default_nettype wire
